// File: rtl/psf_supervisor.sv
// supervisor of a hot-swap supply: enable decode, fault latches, status pins,
// leds, management registers over apb
// assumes all pins synchronous to pclk; sensor values already digitised
//
// Contract
// - inhibit low forces outputs off
// - on only with inhibit open, enable low
// - enable release disables outputs at once
// - warning pin low within 10 C of limit
// - fail pin low on fault shutdown or power loss
// - any output over 125 percent kills all
// - overvoltage latch needs clear condition plus rearm or power loss
// - shutdown at hardware or programmed trip point
// - thermal shutdown restarts when cooled
// - green led steady, blink inhibited, off unpowered
// - amber led on supply or input failure
// - address from three slot position inputs
// - event generator with record store on bus
// - voltages 1 percent, temperature, warn, fail sensors
// - currents quantised in 500 mA steps
// - commands: reset, address, fru, led, firmware
`timescale 1ns/10ps
module psf_supervisor #(
  parameter int BLINK_HALF_CYCLES = psf_pkg::BLINK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic output_inhibit_n,
  input wire logic enable_n,
  input wire logic input_power_ok,
  input wire logic slot_position_bit0,
  input wire logic slot_position_bit1,
  input wire logic slot_position_bit2,
  input wire psf_pkg::psf_sense_t sense,
  output logic outputs_on,
  output logic thermal_warning_n_o,
  output logic thermal_warning_n_oe,
  output logic supply_fail_n_o,
  output logic supply_fail_n_oe,
  output logic led_input,
  output logic led_fault,
  output logic [7:0] mgmt_address
);
  // ===========================================
  // sensor conditioning
  logic [3:0] ov_chan;
  logic [7:0] curr_steps [4];
  logic ov_any;
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_chan
    assign ov_chan[gi] = sense.volt_pct[gi] > psf_pkg::OV_PCT;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        curr_steps[gi] <= 8'h00;
      end else begin
        curr_steps[gi] <= 8'(sense.curr_ma[gi] / psf_pkg::CURR_STEP_MA);
      end
    end
  end
  assign ov_any = |ov_chan;

  // ===========================================
  // apb decode
  logic setup_ph;
  logic wr_acc;
  logic addr_hit;
  logic [7:0] ofs;
  logic [31:0] next_prdata;
  logic [31:0] rd_hold;
  logic rd_mem;
  logic [31:0] mem_rdata;

  assign ofs = paddr[7:0];
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  // zero wait state: every access completes in its first access cycle
  assign pready = 1'b1;

  assign addr_hit = (paddr[31:8] == 24'h000000) && (ofs[1:0] == 2'b00) &&
                    (ofs <= psf_pkg::OFS_FW_DATA);
  assign pslverr = psel && penable && !addr_hit;

  // ===========================================
  // control registers
  logic [7:0] trip_prog;
  logic led_force_en;
  logic led_force_val;
  logic ov_rearm;
  logic soft_reset;
  logic [psf_pkg::REC_AW-1:0] rec_addr;
  logic [15:0] fw_count;
  logic [15:0] fw_sum;

  assign ov_rearm = wr_acc && addr_hit && ofs == psf_pkg::OFS_CTRL &&
                    pwdata[psf_pkg::CTRL_OV_REARM];
  assign soft_reset = wr_acc && addr_hit && ofs == psf_pkg::OFS_CTRL &&
                      pwdata[psf_pkg::CTRL_SOFT_RESET];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_force_en <= 1'b0;
      led_force_val <= 1'b0;
    end else if (soft_reset) begin
      led_force_en <= 1'b0;
      led_force_val <= 1'b0;
    end else if (wr_acc && addr_hit && ofs == psf_pkg::OFS_CTRL) begin
      led_force_en <= pwdata[psf_pkg::CTRL_LED_FORCE_EN];
      led_force_val <= pwdata[psf_pkg::CTRL_LED_FORCE_VAL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_prog <= psf_pkg::HW_TRIP_C;
    end else if (soft_reset) begin
      trip_prog <= psf_pkg::HW_TRIP_C;
    end else if (wr_acc && addr_hit && ofs == psf_pkg::OFS_TRIP) begin
      trip_prog <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_addr <= psf_pkg::REC_ADDR_RESET;
    end else if (wr_acc && addr_hit && ofs == psf_pkg::OFS_REC_ADDR) begin
      rec_addr <= pwdata[psf_pkg::REC_AW-1:0];
    end else if (wr_acc && addr_hit && ofs == psf_pkg::OFS_REC_DATA) begin
      rec_addr <= rec_addr + 1'b1;
    end
  end

  // firmware image words are counted and summed for software to verify
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fw_count <= 16'h0000;
      fw_sum <= 16'h0000;
    end else if (soft_reset) begin
      fw_count <= 16'h0000;
      fw_sum <= 16'h0000;
    end else if (wr_acc && addr_hit && ofs == psf_pkg::OFS_FW_DATA) begin
      fw_count <= fw_count + 16'h0001;
      fw_sum <= fw_sum + pwdata[15:0];
    end
  end

  psf_record_mem u_rec (
    .pclk(pclk),
    .we(wr_acc && addr_hit && ofs == psf_pkg::OFS_REC_DATA),
    .waddr(rec_addr),
    .wdata(pwdata),
    .raddr(rec_addr),
    .rdata(mem_rdata)
  );

  // ===========================================
  // fault latches
  logic ov_latch;
  logic ot_shut;
  logic [7:0] trip_eff;
  logic [8:0] temp_plus;
  logic warn_cond;
  logic fail_cond;

  // the lower of the two trip points wins
  assign trip_eff = (trip_prog < psf_pkg::HW_TRIP_C) ? trip_prog : psf_pkg::HW_TRIP_C;
  assign temp_plus = {1'b0, sense.temp_c} + psf_pkg::WARN_MARGIN_C;
  assign warn_cond = temp_plus >= {1'b0, trip_eff};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_latch <= 1'b0;
    end else if (ov_any) begin
      ov_latch <= 1'b1;
    end else if (ov_rearm || !input_power_ok) begin
      ov_latch <= 1'b0;
    end
  end

  // no hysteresis beyond the one-degree step: restart as soon as below trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_shut <= 1'b0;
    end else begin
      ot_shut <= sense.temp_c >= trip_eff;
    end
  end

  assign fail_cond = ov_latch || ot_shut || !input_power_ok;

  // ===========================================
  // output enable decode
  // combinational so a released enable contact cuts power in the same cycle
  always_comb begin
    outputs_on = output_inhibit_n && !enable_n &&
                 input_power_ok && !ov_any && !ov_latch && !ot_shut;
  end

  // ===========================================
  // open-drain status pins
  assign thermal_warning_n_o = 1'b0;
  assign supply_fail_n_o = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_warning_n_oe <= 1'b0;
      supply_fail_n_oe <= 1'b0;
    end else begin
      thermal_warning_n_oe <= warn_cond;
      supply_fail_n_oe <= fail_cond;
    end
  end

  // ===========================================
  // leds
  logic [$clog2(BLINK_HALF_CYCLES+1)-1:0] blink_cnt;
  logic blink_phase;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end else if (blink_cnt == $bits(blink_cnt)'(BLINK_HALF_CYCLES - 1)) begin
      blink_cnt <= '0;
      blink_phase <= !blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_input <= 1'b0;
      led_fault <= 1'b0;
    end else begin
      led_input <= input_power_ok && (output_inhibit_n || blink_phase);
      led_fault <= led_force_en ? led_force_val : fail_cond;
    end
  end

  // ===========================================
  // management address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_address <= psf_pkg::ADDR_BASE;
    end else begin
      mgmt_address <= psf_pkg::ADDR_BASE + {4'h0, slot_position_bit2,
                      slot_position_bit1, slot_position_bit0, 1'b0};
    end
  end

  // ===========================================
  // event generator
  logic [psf_pkg::EVT_W-1:0] evt_now;
  logic [psf_pkg::EVT_W-1:0] evt_prev;
  logic [psf_pkg::EVT_W-1:0] evt_flags;
  logic [psf_pkg::EVT_W-1:0] evt_clr;

  assign evt_now = {!input_power_ok, fail_cond, warn_cond, ot_shut, ov_latch};
  assign evt_clr = (wr_acc && addr_hit && ofs == psf_pkg::OFS_EVENT) ?
                   pwdata[psf_pkg::EVT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_prev <= '0;
      evt_flags <= '0;
    end else begin
      evt_prev <= evt_now;
      // a new edge in the clearing cycle survives the clear
      evt_flags <= (evt_flags & ~evt_clr) | (evt_now & ~evt_prev);
    end
  end

  // ===========================================
  // read mux
  psf_pkg::psf_status_t status;

  always_comb begin
    status = '{enable_n: enable_n, inhibited: !output_inhibit_n,
               power_ok: input_power_ok, fail: fail_cond, warn: warn_cond,
               ot_shut: ot_shut, ov_latch: ov_latch, outputs_on: outputs_on};
  end

  always_comb begin
    next_prdata = 32'h00000000;
    unique case (ofs)
      psf_pkg::OFS_CTRL: next_prdata = {28'h0000000, led_force_val, led_force_en, 2'b00};
      psf_pkg::OFS_STATUS: next_prdata = {24'h000000, status};
      psf_pkg::OFS_TRIP: next_prdata = {24'h000000, trip_prog};
      psf_pkg::OFS_ADDR: next_prdata = {21'h000000, slot_position_bit2,
                                        slot_position_bit1, slot_position_bit0, mgmt_address};
      psf_pkg::OFS_TEMP: next_prdata = {24'h000000, sense.temp_c};
      psf_pkg::OFS_VOLT: next_prdata = sense.volt_pct;
      psf_pkg::OFS_CURR: next_prdata = {curr_steps[3], curr_steps[2],
                                        curr_steps[1], curr_steps[0]};
      psf_pkg::OFS_EVENT: next_prdata = {27'h0000000, evt_flags};
      psf_pkg::OFS_REC_ADDR: next_prdata = {28'h0000000, rec_addr};
      psf_pkg::OFS_FW_DATA: next_prdata = {fw_count, fw_sum};
      default: next_prdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_hold <= 32'h00000000;
      rd_mem <= 1'b0;
    end else if (setup_ph) begin
      rd_hold <= addr_hit ? next_prdata : 32'h00000000;
      rd_mem <= addr_hit && ofs == psf_pkg::OFS_REC_DATA;
    end
  end

  // record data bypass the hold so a write just before is seen
  assign prdata = rd_mem ? mem_rdata : rd_hold;

  // ===========================================
  // checks
  sequence seq_ov_seen;
    ov_any;
  endsequence
  sequence seq_latched_off;
    ov_latch && !outputs_on;
  endsequence
  chk_inhibit_off: assert property (@(posedge pclk) disable iff (!presetn)
    !output_inhibit_n |-> !outputs_on)
    else $error("outputs on while inhibited");
  chk_enable_decode: assert property (@(posedge pclk) disable iff (!presetn)
    outputs_on |-> output_inhibit_n && !enable_n)
    else $error("outputs on with wrong enable decode");
  chk_late_make: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(enable_n) |-> !outputs_on)
    else $error("outputs stayed on after enable release");
  chk_warn_window: assert property (@(posedge pclk) disable iff (!presetn)
    (temp_plus >= {1'b0, trip_eff}) |=> thermal_warning_n_oe)
    else $error("thermal warning not driven");
  chk_fail_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (ov_latch || ot_shut || !input_power_ok) |=> supply_fail_n_oe)
    else $error("fail pin not driven");
  chk_ov_all_off: assert property (@(posedge pclk) disable iff (!presetn)
    seq_ov_seen |-> !outputs_on ##1 seq_latched_off)
    else $error("overvoltage did not latch all off");
  chk_ov_holds: assert property (@(posedge pclk) disable iff (!presetn)
    ov_latch && !ov_rearm && input_power_ok |=> ov_latch)
    else $error("overvoltage latch cleared without rearm");
  chk_ot_trip: assert property (@(posedge pclk) disable iff (!presetn)
    (sense.temp_c >= trip_prog) |=> ot_shut)
    else $error("programmed trip did not shut down");
  chk_ot_restart: assert property (@(posedge pclk) disable iff (!presetn)
    ot_shut && (sense.temp_c < trip_eff) |=> !ot_shut)
    else $error("no automatic restart after cooling");
  chk_led_unpowered: assert property (@(posedge pclk) disable iff (!presetn)
    !input_power_ok |=> !led_input)
    else $error("input led lit without power");
  chk_fault_led: assert property (@(posedge pclk) disable iff (!presetn)
    !led_force_en && fail_cond |=> led_fault)
    else $error("fault led dark on failure");
  chk_fail_release: assert property (@(posedge pclk) disable iff (!presetn)
    (!fail_cond) [*2] |-> !supply_fail_n_oe)
    else $error("fail pin not released");
endmodule : psf_supervisor

// File: rtl/psf_pkg.sv
// package: constants and carrier types of the supply supervisor
// assumes a 10 MHz pclk and an APB master with 32-bit data
package psf_pkg;
  // ===========================================
  // clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
  // ===========================================
  // limits
  localparam logic [7:0] OV_PCT = 8'h7D;
  localparam logic [8:0] WARN_MARGIN_C = 9'h00A;
  localparam logic [7:0] HW_TRIP_C = 8'h64;
  localparam logic [15:0] CURR_STEP_MA = 16'h01F4;
  localparam logic [7:0] ADDR_BASE = 8'hB0;
  // ===========================================
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TRIP = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_TEMP = 8'h10;
  localparam logic [7:0] OFS_VOLT = 8'h14;
  localparam logic [7:0] OFS_CURR = 8'h18;
  localparam logic [7:0] OFS_EVENT = 8'h1C;
  localparam logic [7:0] OFS_REC_ADDR = 8'h20;
  localparam logic [7:0] OFS_REC_DATA = 8'h24;
  localparam logic [7:0] OFS_FW_DATA = 8'h28;
  // ===========================================
  // ctrl bit positions
  localparam int CTRL_OV_REARM = 0;
  localparam int CTRL_SOFT_RESET = 1;
  localparam int CTRL_LED_FORCE_EN = 2;
  localparam int CTRL_LED_FORCE_VAL = 3;
  // event bit positions
  localparam int EVT_OV = 0;
  localparam int EVT_OT = 1;
  localparam int EVT_WARN = 2;
  localparam int EVT_FAIL = 3;
  localparam int EVT_PWR_LOST = 4;
  localparam int EVT_W = 5;
  // record store
  localparam int REC_AW = 4;
  localparam logic [REC_AW-1:0] REC_ADDR_RESET = 4'h0;
  // ===========================================
  // carriers
  typedef struct packed {
    logic [3:0][7:0] volt_pct;
    logic [3:0][15:0] curr_ma;
    logic [7:0] temp_c;
  } psf_sense_t;

  typedef struct packed {
    logic enable_n;
    logic inhibited;
    logic power_ok;
    logic fail;
    logic warn;
    logic ot_shut;
    logic ov_latch;
    logic outputs_on;
  } psf_status_t;
endpackage : psf_pkg

// File: rtl/psf_record_mem.sv
// sensor record store: small word memory, one write and one read port
// assumes writes and reads come from the register slave in one clock domain
`timescale 1ns/10ps
module psf_record_mem (
  input wire logic pclk,
  input wire logic we,
  input wire logic [psf_pkg::REC_AW-1:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [psf_pkg::REC_AW-1:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [2**psf_pkg::REC_AW];

  // no reset on the array; contents are software's business
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    rdata <= mem[raddr];
  end
endmodule : psf_record_mem

// File: tb/psf_backplane_model.sv
// backplane model: inhibit, enable, power and slot pins seen by the supply
// assumes the bench sets the wanted contact levels; pull-ups on status wires
`timescale 1ns/10ps
module psf_backplane_model (
  input wire logic inh_open,
  input wire logic en_open,
  input wire logic pwr_on,
  input wire logic [2:0] slot_strap,
  input wire logic thermal_warning_n_o,
  input wire logic thermal_warning_n_oe,
  input wire logic supply_fail_n_o,
  input wire logic supply_fail_n_oe,
  output logic output_inhibit_n,
  output logic enable_n,
  output logic input_power_ok,
  output logic [2:0] slot_bits,
  output logic thermal_warning_n,
  output logic supply_fail_n
);
  // ===========================================
  // contacts: an open contact reads high
  assign output_inhibit_n = inh_open;
  assign enable_n = en_open;
  assign input_power_ok = pwr_on;
  assign slot_bits = slot_strap;
  // ===========================================
  // open-drain wires: released means pulled high, never the last value
  assign thermal_warning_n = thermal_warning_n_oe ? thermal_warning_n_o : 1'b1;
  assign supply_fail_n = supply_fail_n_oe ? supply_fail_n_o : 1'b1;
endmodule : psf_backplane_model

// File: tb/psf_supervisor_tb.sv
// testbench of the supply supervisor: pin table, then hand-written cases
// assumes pready answers on its own; 4-cycle blink half period in simulation
`timescale 1ns/10ps
module psf_supervisor_tb;
  typedef struct packed {
    logic inh; logic en; logic pwr; logic [7:0] temp; logic [7:0] volt;
    logic on; logic warn; logic fail; logic led;
  } psf_row_t;
  localparam int HALF = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic inh, en, pwr, err, on, tw_o, tw_oe, sf_o, sf_oe, led_in, led_flt, tw_n, sf_n;
  logic oin, enn, pok, seen0, seen1;
  logic [2:0] slot, sb;
  logic [7:0] maddr;
  psf_pkg::psf_sense_t sense;
  int fails, check_count, cyc;
  psf_row_t rows [10];
  psf_supervisor #(.BLINK_HALF_CYCLES(HALF)) u_psf_supervisor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .output_inhibit_n(oin),
    .enable_n(enn), .input_power_ok(pok), .slot_position_bit0(sb[0]),
    .slot_position_bit1(sb[1]), .slot_position_bit2(sb[2]), .sense(sense), .outputs_on(on),
    .thermal_warning_n_o(tw_o), .thermal_warning_n_oe(tw_oe), .supply_fail_n_o(sf_o),
    .supply_fail_n_oe(sf_oe), .led_input(led_in), .led_fault(led_flt), .mgmt_address(maddr));
  psf_backplane_model u_psf_backplane_model (.inh_open(inh), .en_open(en), .pwr_on(pwr),
    .slot_strap(slot), .thermal_warning_n_o(tw_o), .thermal_warning_n_oe(tw_oe),
    .supply_fail_n_o(sf_o), .supply_fail_n_oe(sf_oe), .output_inhibit_n(oin),
    .enable_n(enn), .input_power_ok(pok), .slot_bits(sb), .thermal_warning_n(tw_n),
    .supply_fail_n(sf_n));
  // ===========================================
  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      print_verdict();
    end
  end
  // ===========================================
  // shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  task print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ===========================================
  // main sequence
  initial begin
    fails = 0; check_count = 0; cyc = 0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    inh = 1'b1; en = 1'b0; pwr = 1'b1; slot = 3'h7; presetn = 1'b0;
    sense = '0;
    sense.volt_pct = {4{8'h64}};
    sense.temp_c = 8'h19;
    rows = '{
      '{1'b0, 1'b0, 1'b1, 8'h19, 8'h64, 1'b0, 1'b0, 1'b0, 1'b0},
      '{1'b0, 1'b1, 1'b1, 8'h19, 8'h64, 1'b0, 1'b0, 1'b0, 1'b0},
      '{1'b1, 1'b0, 1'b1, 8'h19, 8'h64, 1'b1, 1'b0, 1'b0, 1'b0},
      '{1'b1, 1'b1, 1'b1, 8'h19, 8'h64, 1'b0, 1'b0, 1'b0, 1'b0},
      '{1'b1, 1'b0, 1'b1, 8'h5A, 8'h64, 1'b1, 1'b1, 1'b0, 1'b0},
      '{1'b1, 1'b0, 1'b1, 8'h59, 8'h64, 1'b1, 1'b0, 1'b0, 1'b0},
      '{1'b1, 1'b0, 1'b1, 8'h64, 8'h64, 1'b0, 1'b1, 1'b1, 1'b1},
      '{1'b1, 1'b0, 1'b1, 8'h63, 8'h64, 1'b1, 1'b1, 1'b0, 1'b0},
      '{1'b1, 1'b0, 1'b0, 8'h19, 8'h64, 1'b0, 1'b0, 1'b1, 1'b1},
      '{1'b1, 1'b0, 1'b1, 8'h19, 8'h7D, 1'b1, 1'b0, 1'b0, 1'b0}};
    repeat (3) @(posedge pclk);
    chk({tw_oe, sf_oe, led_in, led_flt, maddr}, {4'h0, psf_pkg::ADDR_BASE});
    presetn <= 1'b1;
    settle(2);
    // table: pins in, status pins and leds out
    foreach (rows[i]) begin
      @(posedge pclk);
      inh <= rows[i].inh;
      en <= rows[i].en;
      pwr <= rows[i].pwr;
      sense.temp_c <= rows[i].temp;
      sense.volt_pct[2] <= rows[i].volt;
      settle(3);
      chk(on, rows[i].on);
      chk({~tw_n, ~sf_n, led_flt}, rows[i][2:0]);
      if (rows[i].inh) chk(led_in, rows[i].pwr);
    end
    // overvoltage: immediate, latched, rearmed by command then by power cycle
    @(posedge pclk);
    sense.volt_pct[1] <= 8'h7E;
    @(negedge pclk);
    chk(on, 1'b0);
    @(posedge pclk);
    sense.volt_pct[1] <= 8'h64;
    settle(4);
    chk({on, sf_n}, 2'b00);
    apb(1'b0, psf_pkg::OFS_STATUS, 32'h0);
    chk(rd[1], 1'b1);
    apb(1'b0, psf_pkg::OFS_EVENT, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, psf_pkg::OFS_CTRL, 32'h1);
    settle(2);
    chk(on, 1'b1);
    @(posedge pclk);
    sense.volt_pct[0] <= 8'h80;
    @(posedge pclk);
    sense.volt_pct[0] <= 8'h64;
    pwr <= 1'b0;
    @(posedge pclk);
    pwr <= 1'b1;
    settle(3);
    chk(on, 1'b1);
    // programmed trip point below the hardware one
    apb(1'b1, psf_pkg::OFS_TRIP, 32'h3C);
    apb(1'b0, psf_pkg::OFS_TRIP, 32'h0);
    chk(rd[7:0], 8'h3C);
    sense.temp_c <= 8'h3C;
    settle(3);
    chk({on, tw_n}, 2'b00);
    @(posedge pclk);
    sense.temp_c <= 8'h32;
    settle(3);
    chk({on, tw_n, sf_n}, 3'b101);
    // blink while inhibited
    @(posedge pclk);
    inh <= 1'b0;
    seen0 = 1'b0;
    seen1 = 1'b0;
    repeat (2 * HALF + 2) begin
      @(negedge pclk);
      seen0 = seen0 | (led_in === 1'b0);
      seen1 = seen1 | (led_in === 1'b1);
    end
    chk({seen0, seen1}, 2'b11);
    @(posedge pclk);
    inh <= 1'b1;
    // slot position bits, all eight strappings
    for (int s = 0; s < 8; s++) begin
      slot <= s[2:0];
      settle(2);
      chk(maddr, psf_pkg::ADDR_BASE + {4'h0, s[2:0], 1'b0});
      apb(1'b0, psf_pkg::OFS_ADDR, 32'h0);
      chk(rd[10:0], {s[2:0], psf_pkg::ADDR_BASE + {4'h0, s[2:0], 1'b0}});
    end
    // sensor readings; channel 2 still sits at the 125 percent edge
    sense.curr_ma[0] <= 16'h05DB;
    sense.volt_pct[3] <= 8'h5F;
    settle(3);
    apb(1'b0, psf_pkg::OFS_CURR, 32'h0);
    chk(rd[7:0], 8'h02);
    apb(1'b0, psf_pkg::OFS_VOLT, 32'h0);
    chk(rd, 32'h5F7D6464);
    apb(1'b0, psf_pkg::OFS_TEMP, 32'h0);
    chk(rd[7:0], 8'h32);
    // record store: auto-increment on write, wraps, reads leave the address
    apb(1'b1, psf_pkg::OFS_REC_ADDR, 32'hF);
    apb(1'b1, psf_pkg::OFS_REC_DATA, 32'hA5A5_0001);
    apb(1'b1, psf_pkg::OFS_REC_DATA, 32'h5A5A_0002);
    apb(1'b0, psf_pkg::OFS_REC_ADDR, 32'h0);
    chk(rd[3:0], 4'h1);
    apb(1'b1, psf_pkg::OFS_REC_ADDR, 32'h0);
    apb(1'b0, psf_pkg::OFS_REC_DATA, 32'h0);
    chk(rd, 32'h5A5A_0002);
    apb(1'b1, psf_pkg::OFS_REC_ADDR, 32'hF);
    apb(1'b0, psf_pkg::OFS_REC_DATA, 32'h0);
    chk(rd, 32'hA5A5_0001);
    apb(1'b0, psf_pkg::OFS_REC_ADDR, 32'h0);
    chk(rd[3:0], 4'hF);
    // every event has fired by now; clearing leaves nothing with steady levels
    apb(1'b0, psf_pkg::OFS_EVENT, 32'h0);
    chk(rd[4:0], 5'h1F);
    apb(1'b1, psf_pkg::OFS_EVENT, 32'h1F);
    apb(1'b0, psf_pkg::OFS_EVENT, 32'h0);
    chk(rd[4:0], 5'h00);
    // firmware words, fault led force, controller reset
    apb(1'b1, psf_pkg::OFS_FW_DATA, 32'h0000_1000);
    apb(1'b1, psf_pkg::OFS_FW_DATA, 32'h0000_0234);
    apb(1'b0, psf_pkg::OFS_FW_DATA, 32'h0);
    chk(rd, 32'h0002_1234);
    apb(1'b1, psf_pkg::OFS_CTRL, 32'hC);
    settle(2);
    chk(led_flt, 1'b1);
    apb(1'b1, psf_pkg::OFS_CTRL, 32'h2);
    apb(1'b0, psf_pkg::OFS_TRIP, 32'h0);
    chk({rd[7:0], err}, {psf_pkg::HW_TRIP_C, 1'b0});
    apb(1'b0, psf_pkg::OFS_FW_DATA, 32'h0);
    chk(rd, 32'h0000_0000);
    settle(2);
    chk(led_flt, 1'b0);
    // unmapped place is refused
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    print_verdict();
  end
endmodule : psf_supervisor_tb
